// >>> rtl/aifsv_pkg.sv
package aifsv_pkg;

	// ==========================================================
	// Sizes and types
	localparam int NCH = 32'h8;
	localparam int CODE_W = 32'h10;
	localparam int FCODE_W = 32'h5;
	localparam int CH_IDX_W = 32'h3;
	typedef logic [CODE_W-1:0] code_t;
	typedef logic [FCODE_W-1:0] fcode_t;
	typedef logic [CH_IDX_W-1:0] ch_idx_t;

	// ==========================================================
	// Current scale: the converter spans 0 to 25 mA over the full code range
	localparam int FULL_UA = 32'h61a8;
	localparam int FULL_CODE = 32'hffff;
	localparam int SHORT_UA = 32'h57e4;
	localparam int WIRE_UA = 32'h2ee;
	localparam int FOUR_MA_UA = 32'hfa0;
	localparam code_t SHORT_CODE = code_t'(SHORT_UA * FULL_CODE / FULL_UA);
	localparam code_t WIRE_CODE = code_t'(WIRE_UA * FULL_CODE / FULL_UA);
	localparam code_t FOUR_MA_CODE = code_t'(FOUR_MA_UA * FULL_CODE / FULL_UA);
	localparam code_t CODE_MAX = 16'hffff;
	localparam code_t CODE_ZERO = 16'h0000;
	// 4-20 mA span: (I-4)/20 against I/25, a ratio of 5/4
	localparam int SCALE_NUM = 32'h5;
	localparam int SCALE_SHIFT = 32'h2;

	// ==========================================================
	// Diagnosis fault codes and byte framing
	localparam fcode_t FC_NONE = 5'h00;
	localparam fcode_t FC_SHORT = 5'h01;
	localparam fcode_t FC_WIRE = 5'h06;
	localparam fcode_t FC_UPPER = 5'h07;
	localparam fcode_t FC_LOWER = 5'h08;
	localparam fcode_t FC_ACQ = 5'h12;
	localparam logic [7:0] HEAD_BYTE = 8'h80;
	localparam logic [7:0] CHAN_BYTE_BASE = 8'h40;
	localparam logic [7:0] FAULT_BYTE_BASE = 8'ha0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_head = 4'h2,
		st_chan = 4'h4,
		st_code = 4'h8
	} diag_state_t;

	// ==========================================================
	// Map a converter code onto the 4-20 mA channel code, saturating
	function automatic code_t scale_4_20(input code_t raw);
		logic [18:0] span;
		span = 19'h00000;
		if (raw <= FOUR_MA_CODE) begin
			return CODE_ZERO;
		end
		span = (19'(raw) - 19'(FOUR_MA_CODE)) * 19'(SCALE_NUM);
		span = span >> SCALE_SHIFT;
		if (span > 19'(CODE_MAX)) begin
			return CODE_MAX;
		end
		return span[15:0];
	endfunction

	// Lowest set bit of a pending mask
	function automatic ch_idx_t first_set(input logic [NCH-1:0] mask);
		ch_idx_t idx;
		idx = ch_idx_t'(0);
		for (int k = NCH - 1; k >= 0; k--) begin
			if (mask[k]) begin
				idx = ch_idx_t'(k);
			end
		end
		return idx;
	endfunction

endpackage

// >>> rtl/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
	aifsv_pkg::code_t raw;
	aifsv_pkg::code_t upper;
	aifsv_pkg::code_t lower;
	aifsv_pkg::code_t scaled;
	aifsv_pkg::fcode_t code;
	logic range_4_20;
	logic line_en;
	logic upper_en;
	logic lower_en;
	logic acq_fault;

	modport classifier(
		input raw, upper, lower, range_4_20, line_en, upper_en, lower_en, acq_fault,
		output scaled, code
	);
	modport owner(
		output raw, upper, lower, range_4_20, line_en, upper_en, lower_en, acq_fault,
		input scaled, code
	);
endinterface

// >>> rtl/fault_classifier.sv
`timescale 1ns/1ps
module fault_classifier (
	chan_if.classifier lane
);

	// ==========================================================
	// Scaling and threshold hits
	wire logic short_hit;
	wire logic wire_hit;
	wire logic upper_hit;
	wire logic lower_hit;

	assign lane.scaled = lane.range_4_20 ? aifsv_pkg::scale_4_20(lane.raw) : lane.raw;
	// Short and break look at the raw converter code: below 4 mA the 4-20 code is clamped
	assign short_hit = lane.line_en && (lane.raw > aifsv_pkg::SHORT_CODE);
	assign wire_hit = lane.line_en && lane.range_4_20 && (lane.raw < aifsv_pkg::WIRE_CODE);
	assign upper_hit = lane.upper_en && (lane.scaled > lane.upper)
		&& (lane.scaled < aifsv_pkg::CODE_MAX);
	assign lower_hit = lane.lower_en && (lane.scaled > aifsv_pkg::CODE_ZERO)
		&& (lane.scaled < lane.lower);

	// ==========================================================
	// One code per channel, most severe first
	assign lane.code = lane.acq_fault ? aifsv_pkg::FC_ACQ :
		short_hit ? aifsv_pkg::FC_SHORT :
		wire_hit ? aifsv_pkg::FC_WIRE :
		upper_hit ? aifsv_pkg::FC_UPPER :
		lower_hit ? aifsv_pkg::FC_LOWER :
		aifsv_pkg::FC_NONE;

endmodule

// >>> rtl/analog_input_fault_safety_value.sv
// What this block does
// - In 4-20 mA flag short above 22.5 mA, wire break below 0.75 mA.
// - In 0-20 mA flag short above 22.5 mA; never flag wire break.
// - Flag upper/lower limit violations inside the measurable span only.
// - All channel faults are re-evaluated on every scan, not once.
// - Any channel fault raises its quality flag and substitutes a safety value.
// - Lost link or module failure drives every enabled channel safe.
// - Flag 1 means fault with safety value; 0 means normal acquired value.
// - Hold mode: faulted channel keeps its previous value while faulted.
// - Preset mode: faulted channel reports its preset safety value.
// - The live value output is the post-substitution value.
// - Image slots 1-8 carry values, slots 9-16 the matching flags.
// - Preset values are range-scaled codes supplied by the configurer.
// - Report acquisition fault as header, channel byte, fault byte 0xb2.
// - A cleared fault drops its flag with no operator acknowledge.
// - Fault byte is 101 plus code: 0,1,6,7,8 for recovery..lower.
// - Short, break and limit faults only when that diagnosis is enabled.
`timescale 1ns/1ps
module analog_input_fault_safety_value (
	input wire logic clk,
	input wire logic rst,
	input wire logic sample_valid,
	input wire aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] raw_code,
	input wire logic [aifsv_pkg::NCH-1:0] acq_fault,
	input wire logic module_fault,
	input wire logic link_lost,
	input wire logic [aifsv_pkg::NCH-1:0] ch_enable,
	input wire logic [aifsv_pkg::NCH-1:0] range_4_20,
	input wire logic [aifsv_pkg::NCH-1:0] line_diag_en,
	input wire logic [aifsv_pkg::NCH-1:0] upper_diag_en,
	input wire logic [aifsv_pkg::NCH-1:0] lower_diag_en,
	input wire aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] upper_limit,
	input wire aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] lower_limit,
	input wire logic [aifsv_pkg::NCH-1:0] preset_mode,
	input wire aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] preset_value,
	input wire logic diag_ready,
	output logic [aifsv_pkg::NCH-1:0] channel_fault_flag,
	output aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] live_channel_value,
	output aifsv_pkg::code_t [2*aifsv_pkg::NCH-1:0] channel_image,
	output logic any_fault,
	output logic [7:0] diag_byte,
	output logic diag_valid
);

	// ==========================================================
	// Per-channel classification
	wire logic forced;
	wire aifsv_pkg::fcode_t [aifsv_pkg::NCH-1:0] cls_code;
	wire aifsv_pkg::fcode_t [aifsv_pkg::NCH-1:0] code_now;
	wire aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] scaled;
	wire aifsv_pkg::code_t [aifsv_pkg::NCH-1:0] next_value;
	wire aifsv_pkg::code_t [2*aifsv_pkg::NCH-1:0] next_image;
	wire logic [aifsv_pkg::NCH-1:0] fault_now;
	wire logic [aifsv_pkg::NCH-1:0] change;
	aifsv_pkg::fcode_t [aifsv_pkg::NCH-1:0] code_q;

	// Link loss is not a channel code: it forces the flag but sends no channel diagnosis
	assign forced = module_fault | link_lost;

	for (genvar i = 0; i < aifsv_pkg::NCH; i++) begin : g_ch
		chan_if lane();
		assign lane.raw = raw_code[i];
		assign lane.upper = upper_limit[i];
		assign lane.lower = lower_limit[i];
		assign lane.range_4_20 = range_4_20[i];
		assign lane.line_en = line_diag_en[i];
		assign lane.upper_en = upper_diag_en[i];
		assign lane.lower_en = lower_diag_en[i];
		assign lane.acq_fault = acq_fault[i];
		fault_classifier u_cls (
			.lane(lane)
		);
		assign scaled[i] = lane.scaled;
		// A disabled channel ignores its mode and preset entirely
		assign cls_code[i] = ch_enable[i] ? lane.code : aifsv_pkg::FC_NONE;
		// Every scan replaces the stored code, so faults are tracked continuously
		assign code_now[i] = sample_valid ? cls_code[i] : code_q[i];
		assign fault_now[i] = ch_enable[i] & (forced | (code_now[i] != aifsv_pkg::FC_NONE));
		assign next_value[i] = !ch_enable[i] ? aifsv_pkg::CODE_ZERO :
			fault_now[i] ? (preset_mode[i] ? preset_value[i] : live_channel_value[i]) :
			sample_valid ? scaled[i] : live_channel_value[i];
		assign change[i] = sample_valid & ch_enable[i] & (cls_code[i] != code_q[i]);
		assign next_image[i] = next_value[i];
		assign next_image[i+aifsv_pkg::NCH] = {15'h0000, fault_now[i]};
	end

	// ==========================================================
	// Channel outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			code_q <= '{default: aifsv_pkg::FC_NONE};
			channel_fault_flag <= 8'h00;
			live_channel_value <= '{default: aifsv_pkg::CODE_ZERO};
			channel_image <= '{default: aifsv_pkg::CODE_ZERO};
			any_fault <= 1'b0;
		end else begin
			code_q <= code_now;
			channel_fault_flag <= fault_now;
			live_channel_value <= next_value;
			channel_image <= next_image;
			any_fault <= |fault_now;
		end
	end

	// ==========================================================
	// Diagnosis sender: one three-byte sequence per pending channel; code changes merge until it is picked
	aifsv_pkg::diag_state_t state;
	aifsv_pkg::diag_state_t next_state;
	logic [aifsv_pkg::NCH-1:0] pending;
	aifsv_pkg::ch_idx_t sel_ch;
	aifsv_pkg::fcode_t sel_code;
	logic [7:0] next_byte;
	logic next_valid;
	wire logic start;
	wire logic take;
	wire aifsv_pkg::ch_idx_t pick;
	wire logic [aifsv_pkg::NCH-1:0] pick_mask;
	wire logic [aifsv_pkg::NCH-1:0] next_pending;
	wire logic [7:0] chan_byte;
	wire logic [7:0] fault_byte;

	assign start = (state == aifsv_pkg::st_idle) && (|pending);
	assign take = diag_valid & diag_ready;
	assign pick = aifsv_pkg::first_set(pending);
	assign pick_mask = start ? (8'h01 << pick) : 8'h00;
	// New change wins over the clear of the bit being picked
	assign next_pending = (pending & ~pick_mask) | change;
	assign chan_byte = aifsv_pkg::CHAN_BYTE_BASE | {5'h00, sel_ch};
	assign fault_byte = aifsv_pkg::FAULT_BYTE_BASE | {3'h0, sel_code};

	always_comb begin
		next_state = state;
		next_byte = diag_byte;
		next_valid = diag_valid;
		case (state)
			aifsv_pkg::st_idle: begin
				if (start) begin
					next_state = aifsv_pkg::st_head;
					next_byte = aifsv_pkg::HEAD_BYTE;
					next_valid = 1'b1;
				end
			end
			aifsv_pkg::st_head: begin
				if (take) begin
					next_state = aifsv_pkg::st_chan;
					next_byte = chan_byte;
				end
			end
			aifsv_pkg::st_chan: begin
				if (take) begin
					next_state = aifsv_pkg::st_code;
					next_byte = fault_byte;
				end
			end
			aifsv_pkg::st_code: begin
				if (take) begin
					next_state = aifsv_pkg::st_idle;
					next_byte = aifsv_pkg::BYTE_ZERO;
					next_valid = 1'b0;
				end
			end
			default: begin
				next_state = aifsv_pkg::st_idle;
				next_byte = aifsv_pkg::BYTE_ZERO;
				next_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= aifsv_pkg::st_idle;
			pending <= 8'h00;
			sel_ch <= 3'h0;
			sel_code <= aifsv_pkg::FC_NONE;
			diag_byte <= aifsv_pkg::BYTE_ZERO;
			diag_valid <= 1'b0;
		end else begin
			state <= next_state;
			pending <= next_pending;
			diag_byte <= next_byte;
			diag_valid <= next_valid;
			if (start) begin
				sel_ch <= pick;
				// Code taken at pick time; a later change re-arms the channel
				sel_code <= code_q[pick];
			end
		end
	end

	// ==========================================================
	// Checks
	for (genvar i = 0; i < aifsv_pkg::NCH; i++) begin : g_chk
		short_detect_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && line_diag_en[i] && !acq_fault[i]
				&& raw_code[i] > aifsv_pkg::SHORT_CODE)
			|=> channel_fault_flag[i] && code_q[i] == aifsv_pkg::FC_SHORT)
			else $error("short circuit not flagged");
		no_break_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && !range_4_20[i]) |=> code_q[i] != aifsv_pkg::FC_WIRE)
			else $error("wire break flagged in 0-20 mA range");
		wire_break_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && line_diag_en[i] && range_4_20[i]
				&& !acq_fault[i] && raw_code[i] < aifsv_pkg::WIRE_CODE)
			|=> code_q[i] == aifsv_pkg::FC_WIRE)
			else $error("wire break not flagged");
		diag_gate_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && !acq_fault[i] && !line_diag_en[i] && !upper_diag_en[i]
				&& !lower_diag_en[i]) |=> code_q[i] == aifsv_pkg::FC_NONE)
			else $error("fault reported with diagnosis disabled");
		hold_value_a: assert property (@(posedge clk) disable iff (rst)
			(ch_enable[i] && !preset_mode[i] && fault_now[i])
			|=> live_channel_value[i] == $past(live_channel_value[i]))
			else $error("held value changed during fault");
		preset_value_a: assert property (@(posedge clk) disable iff (rst)
			(ch_enable[i] && preset_mode[i] && fault_now[i])
			|=> channel_fault_flag[i] && live_channel_value[i] == $past(preset_value[i]))
			else $error("preset safety value not delivered");
		forced_safe_a: assert property (@(posedge clk) disable iff (rst)
			(forced && ch_enable[i]) |=> channel_fault_flag[i])
			else $error("link or module fault did not force safe side");
		auto_clear_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && !forced && cls_code[i] == aifsv_pkg::FC_NONE)
			|=> !channel_fault_flag[i])
			else $error("flag held after fault cleared");
		image_slots_a: assert property (@(posedge clk) disable iff (rst)
			channel_image[i] == live_channel_value[i]
			&& channel_image[i+aifsv_pkg::NCH] == {15'h0000, channel_fault_flag[i]})
			else $error("channel image slot mismatch");
	end

	diag_frame_a: assert property (@(posedge clk) disable iff (rst)
		(take && diag_byte == aifsv_pkg::HEAD_BYTE)
		|=> diag_valid && diag_byte[7:3] == 5'h08)
		else $error("channel byte does not follow header");
	fault_byte_a: assert property (@(posedge clk) disable iff (rst)
		(take && state == aifsv_pkg::st_chan) |=> diag_valid && diag_byte[7:5] == 3'h5)
		else $error("fault byte prefix wrong");
	any_fault_a: assert property (@(posedge clk) disable iff (rst)
		any_fault == (|channel_fault_flag))
		else $error("summary fault flag disagrees with channel flags");
	head_first_a: assert property (@(posedge clk) disable iff (rst)
		$rose(diag_valid) |-> diag_byte == aifsv_pkg::HEAD_BYTE)
		else $error("diagnosis sequence does not open with header");
	byte_stands_a: assert property (@(posedge clk) disable iff (rst)
		(diag_valid && !diag_ready) |=> diag_valid && $stable(diag_byte))
		else $error("diagnosis byte dropped before it was taken");
	sequence_gap_a: assert property (@(posedge clk) disable iff (rst)
		(take && state == aifsv_pkg::st_code) |=> !diag_valid)
		else $error("no idle cycle after fault byte");

	// ==========================================================
	// Classification and substitution checks
	for (genvar i = 0; i < aifsv_pkg::NCH; i++) begin : g_cls_chk
		upper_limit_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && upper_diag_en[i] && !acq_fault[i]
				&& raw_code[i] <= aifsv_pkg::SHORT_CODE
				&& (!range_4_20[i] || raw_code[i] >= aifsv_pkg::WIRE_CODE)
				&& scaled[i] > upper_limit[i] && scaled[i] < aifsv_pkg::CODE_MAX)
			|=> code_q[i] == aifsv_pkg::FC_UPPER)
			else $error("upper limit not flagged");
		lower_limit_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && lower_diag_en[i] && !acq_fault[i]
				&& raw_code[i] <= aifsv_pkg::SHORT_CODE
				&& (!range_4_20[i] || raw_code[i] >= aifsv_pkg::WIRE_CODE)
				&& scaled[i] > aifsv_pkg::CODE_ZERO && scaled[i] < lower_limit[i]
				&& scaled[i] <= upper_limit[i]) |=> code_q[i] == aifsv_pkg::FC_LOWER)
			else $error("lower limit not flagged");
		acq_code_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && acq_fault[i])
			|=> channel_fault_flag[i] && code_q[i] == aifsv_pkg::FC_ACQ)
			else $error("acquisition fault not flagged");
		disabled_zero_a: assert property (@(posedge clk) disable iff (rst)
			!ch_enable[i]
			|=> !channel_fault_flag[i] && live_channel_value[i] == aifsv_pkg::CODE_ZERO)
			else $error("disabled channel not quiet");
		value_pass_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && !forced && cls_code[i] == aifsv_pkg::FC_NONE)
			|=> live_channel_value[i] == $past(scaled[i]))
			else $error("clean sample not delivered");
		rescan_a: assert property (@(posedge clk) disable iff (rst)
			sample_valid |=> code_q[i] == $past(cls_code[i]))
			else $error("scan did not refresh channel code");
		code_hold_a: assert property (@(posedge clk) disable iff (rst)
			!sample_valid |=> code_q[i] == $past(code_q[i]))
			else $error("channel code moved between scans");
		line_gate_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && !line_diag_en[i])
			|=> code_q[i] != aifsv_pkg::FC_SHORT && code_q[i] != aifsv_pkg::FC_WIRE)
			else $error("line fault reported with line diagnosis off");
		clamp_low_a: assert property (@(posedge clk) disable iff (rst)
			(range_4_20[i] && raw_code[i] <= aifsv_pkg::FOUR_MA_CODE) |-> scaled[i] == 16'h0000)
			else $error("4-20 code not clamped below 4 mA");
		plain_scale_a: assert property (@(posedge clk) disable iff (rst)
			!range_4_20[i] |-> scaled[i] == raw_code[i])
			else $error("0-20 code altered");
		recovery_arm_a: assert property (@(posedge clk) disable iff (rst)
			(sample_valid && ch_enable[i] && code_q[i] != aifsv_pkg::FC_NONE
				&& cls_code[i] == aifsv_pkg::FC_NONE) |=> pending[i])
			else $error("recovery not queued for diagnosis");
	end

endmodule

// >>> dv/diag_sink.sv
`timescale 1ns/1ps
module diag_sink (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] diag_byte,
	input wire logic diag_valid,
	input wire logic stall,
	output logic diag_ready,
	output logic [23:0] last3,
	output logic [15:0] nbytes
);
	// ==========================================================
	// Controller side of the diagnosis byte stream
	// Ready is registered so it only ever moves just after an edge,
	// which lets the bench stall the stream without racing the block
	always @(posedge clk) begin
		if (rst) begin
			last3 <= 24'h000000;
			nbytes <= 16'h0000;
			diag_ready <= #1 1'b0;
		end else begin
			if (diag_valid && diag_ready) begin
				last3 <= {last3[15:0], diag_byte};
				nbytes <= nbytes + 16'h0001;
			end
			diag_ready <= #1 ~stall;
		end
	end
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sample_valid = 1'b0;
	aifsv_pkg::code_t [7:0] raw_code = {8{16'h7530}};
	logic [7:0] acq_fault = 8'h00;
	logic module_fault = 1'b0;
	logic link_lost = 1'b0;
	logic [7:0] ch_enable = 8'h7f;
	logic [7:0] range_4_20 = 8'h02;
	logic [7:0] line_diag_en = 8'hdf;
	logic [7:0] upper_diag_en = 8'hff;
	logic [7:0] lower_diag_en = 8'hff;
	aifsv_pkg::code_t [7:0] upper_limit = {{4{16'hfffe}}, 16'h9c40, {3{16'hfffe}}};
	aifsv_pkg::code_t [7:0] lower_limit = {{3{16'h0000}}, 16'h4e20, {4{16'h0000}}};
	logic [7:0] preset_mode = 8'h01;
	aifsv_pkg::code_t [7:0] preset_value = {8{16'h1234}};
	logic [7:0] channel_fault_flag;
	aifsv_pkg::code_t [7:0] live_channel_value;
	aifsv_pkg::code_t [15:0] channel_image;
	logic any_fault, diag_valid, diag_ready, stall = 1'b0;
	logic [7:0] diag_byte;
	logic [23:0] last3;
	logic [15:0] nbytes;
	int fail_count = 0;
	int cmp_count = 0;
	// Below 4 mA the 4-20 code clamps, so expectations use raw above it
	localparam int FOUR = 4000 * 65535 / 25000;
	localparam logic [15:0] NORM1 = 16'((30000 - FOUR) * 5 / 4);
	localparam logic [15:0] NORM2 = 16'((20000 - FOUR) * 5 / 4);

	always #25 clk = ~clk;

	analog_input_fault_safety_value DUT (.clk(clk), .rst(rst), .sample_valid(sample_valid),
		.raw_code(raw_code), .acq_fault(acq_fault), .module_fault(module_fault),
		.link_lost(link_lost), .ch_enable(ch_enable), .range_4_20(range_4_20),
		.line_diag_en(line_diag_en), .upper_diag_en(upper_diag_en),
		.lower_diag_en(lower_diag_en), .upper_limit(upper_limit), .lower_limit(lower_limit),
		.preset_mode(preset_mode), .preset_value(preset_value), .diag_ready(diag_ready),
		.channel_fault_flag(channel_fault_flag), .live_channel_value(live_channel_value),
		.channel_image(channel_image), .any_fault(any_fault), .diag_byte(diag_byte),
		.diag_valid(diag_valid));
	diag_sink sink (.clk(clk), .rst(rst), .diag_byte(diag_byte), .diag_valid(diag_valid),
		.stall(stall), .diag_ready(diag_ready), .last3(last3), .nbytes(nbytes));

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic scan(input int ch, input logic [15:0] code);
		raw_code[ch] = code;
		sample_valid = 1'b1;
		@(posedge clk);
		#1;
		sample_valid = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic chan(input int ch, input logic f, input logic [15:0] v);
		chk(24'(channel_fault_flag[ch]), 24'(f));
		chk(24'(live_channel_value[ch]), 24'(v));
		chk(24'(channel_image[ch]), 24'(v));
		chk(24'(channel_image[ch+8]), 24'(f));
	endtask
	task automatic diag(input int ch, input logic [4:0] code);
		logic [15:0] n0;
		n0 = nbytes;
		for (int i = 0; i < 40 && nbytes < n0 + 16'h0003; i++) begin
			@(posedge clk);
			#1;
		end
		chk(24'(nbytes - n0), 24'h000003);
		chk(last3, {8'h80, 8'h40 | 8'(ch), 8'ha0 | 8'(code)});
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		chk(24'({any_fault, diag_valid}), 24'h000000);
		scan(0, 16'h7530);
		chan(0, 1'b0, 16'h7530);
		chan(1, 1'b0, NORM1);
		chan(7, 1'b0, 16'h0000);
		$display("test normal done");
		scan(0, 16'hea60);
		chan(0, 1'b1, 16'h1234);
		chk(24'(any_fault), 24'h000001);
		diag(0, 5'h01);
		scan(0, 16'h7530);
		chan(0, 1'b0, 16'h7530);
		diag(0, 5'h00);
		$display("test short done");
		scan(1, 16'h03e8);
		chan(1, 1'b1, NORM1);
		diag(1, 5'h06);
		scan(2, 16'h03e8);
		chan(2, 1'b0, 16'h03e8);
		scan(1, 16'h4e20);
		chan(1, 1'b0, NORM2);
		diag(1, 5'h00);
		$display("test break done");
		stall = 1'b1;
		scan(3, 16'hafc8);
		chan(3, 1'b1, 16'h7530);
		repeat (4) @(posedge clk);
		#1;
		chk(24'({diag_valid, diag_byte}), 24'h000180);
		stall = 1'b0;
		diag(3, 5'h07);
		scan(3, 16'h7530);
		diag(3, 5'h00);
		scan(4, 16'h2710);
		chan(4, 1'b1, 16'h7530);
		diag(4, 5'h08);
		scan(4, 16'h7530);
		diag(4, 5'h00);
		scan(5, 16'hea60);
		chan(5, 1'b0, 16'hea60);
		scan(5, 16'h7530);
		$display("test limits done");
		acq_fault[6] = 1'b1;
		scan(6, 16'h7530);
		chan(6, 1'b1, 16'h7530);
		diag(6, 5'h12);
		acq_fault[6] = 1'b0;
		scan(6, 16'h7530);
		diag(6, 5'h00);
		$display("test acquisition done");
		link_lost = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(24'(channel_fault_flag), 24'h00007f);
		chan(0, 1'b1, 16'h1234);
		link_lost = 1'b0;
		module_fault = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(24'(channel_fault_flag), 24'h00007f);
		module_fault = 1'b0;
		scan(0, 16'h7530);
		chk(24'({any_fault, channel_fault_flag}), 24'h000000);
		chk(24'(nbytes), 24'h00001e);
		$display("test link done");
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk(24'({any_fault, diag_valid, channel_fault_flag}), 24'h000000);
		chk(24'(live_channel_value[0]), 24'h000000);
		chk(24'(channel_image[0]), 24'h000000);
		scan(2, 16'h7530);
		chan(2, 1'b0, 16'h7530);
		chk(24'(diag_valid), 24'h000000);
		$display("test reset done");
		stop_test();
	end

	initial begin
		#500000;
		fail_count++;
		stop_test();
	end
endmodule
